/* common/crs_pkg.sv */
// Constants and types for the call and return execution block
// What this block does
// [RULE1] A push writes PC plus 2 into the stack top and moves the old top one level down.
// [RULE2] The relative call takes a signed word offset from -1024 to +1023.
// [RULE3] The relative call is decoded from top nibble 1101 then a set bit, with an 11-bit offset.
// [RULE4] A relative call pushes PC plus 2, then loads PC with PC plus 2 plus twice the offset.
// [RULE5] Relative call and the three returns take two instruction cycles, the second a no-op.
// [RULE6] Software reset takes one cycle, starts reset in phase two and resets all registers.
// [RULE7] Interrupt return is 0000 0000 0001 000 plus a shadow-restore option bit.
// [RULE8] Interrupt return pops the stack and loads the PC in phase four of its first cycle.
// [RULE9] Interrupt return sets the high or low global interrupt enable and, with option 0, no other flag.
// [RULE10] Interrupt return with option 1 restores working, flags and bank select from shadows.
// [RULE11] No return changes the upper or high PC latch registers.
// [RULE12] Return with literal is decoded from upper byte 0000 1100 with an 8-bit literal.
// [RULE13] Return with literal loads the working register, pops into the PC, touches no flag.
// [RULE14] Subroutine return is 0000 0000 0001 001 plus an option bit, like interrupt return.
// [RULE15] Subroutine return pops the stack into the PC and, with option 0, changes no flag.
// [RULE16] Subroutine return with option 1 restores working, flags and bank select from shadows.
// [RULE17] The stack pointer rises by one on push or call and falls by one on pop or return.
package crs_pkg;
  localparam int          PC_W        = 21;
  localparam int          SP_W        = 5;
  localparam int          DEPTH       = 31;
  localparam logic [15:0] OP_PUSH     = 16'h0005;
  localparam logic [15:0] OP_RESET    = 16'h00FF;
  localparam logic [14:0] OP_RETI_HI  = 15'h0008;
  localparam logic [14:0] OP_RETS_HI  = 15'h0009;
  localparam logic [7:0]  OP_RETL_HI  = 8'h0C;
  localparam logic [4:0]  OP_RELATIVE_CALL_OP_HI = 5'h1B;
  localparam logic [1:0]  PH_Q1       = 2'h0;
  localparam logic [1:0]  PH_Q2       = 2'h1;
  localparam logic [1:0]  PH_Q4       = 2'h3;
  localparam logic [PC_W-1:0] PC_RST  = 21'h00_0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  typedef enum logic [2:0] {
    CRS_NONE  = 3'b000,
    CRS_PUSH  = 3'b001,
    CRS_RELATIVE_CALL_OP = 3'b010,
    CRS_RESET = 3'b011,
    CRS_RETI  = 3'b100,
    CRS_RETL  = 3'b101,
    CRS_RETS  = 3'b110
  } crs_op_t;
endpackage

/* design/crs_decode.sv */
// Opcode decoder for the call and return group
`timescale 1ns/1ps
module crs_decode (
  input  wire logic [15:0]       opcode,
  output crs_pkg::crs_op_t       op,
  output logic                   shadow_sel,
  output logic [10:0]            offset
);
  always_comb begin
    op         = crs_pkg::CRS_NONE;
    shadow_sel = opcode[0];
    offset     = opcode[10:0]; // see [RULE2]
    if (opcode == crs_pkg::OP_PUSH) begin
      op = crs_pkg::CRS_PUSH;
    end else if (opcode == crs_pkg::OP_RESET) begin
      op = crs_pkg::CRS_RESET;
    end else if (opcode[15:1] == crs_pkg::OP_RETI_HI) begin // see [RULE7]
      op = crs_pkg::CRS_RETI;
    end else if (opcode[15:1] == crs_pkg::OP_RETS_HI) begin // see [RULE14]
      op = crs_pkg::CRS_RETS;
    end else if (opcode[15:8] == crs_pkg::OP_RETL_HI) begin // see [RULE12]
      op = crs_pkg::CRS_RETL;
    end else if (opcode[15:11] == crs_pkg::OP_RELATIVE_CALL_OP_HI) begin // see [RULE3]
      op = crs_pkg::CRS_RELATIVE_CALL_OP;
    end
  end
endmodule

/* design/crs_core.sv */
// Call, return, push and software reset execution with return stack
`timescale 1ns/1ps
module crs_core (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic [15:0]              opcode,
  input  wire logic                     op_valid,
  input  wire logic                     irq_low_level,
  input  wire logic [7:0]               working_shadow,
  input  wire logic [7:0]               flags_shadow,
  input  wire logic [7:0]               bank_select_shadow,
  input  wire logic [4:0]               upper_pc_latch_in,
  input  wire logic [7:0]               high_pc_latch_in,
  input  wire logic                     latch_we,
  output logic [crs_pkg::PC_W-1:0]      pc_q,
  output logic [crs_pkg::PC_W-1:0]      stack_top_value_q,
  output logic [crs_pkg::SP_W-1:0]      sp_q,
  output logic [7:0]                    working_q,
  output logic [7:0]                    flags_q,
  output logic [7:0]                    bank_select_q,
  output logic                          global_irq_enable_high_q,
  output logic                          peripheral_irq_enable_low_q,
  output logic [4:0]                    upper_pc_latch_q,
  output logic [7:0]                    high_pc_latch_q,
  output logic [1:0]                    phase_q,
  output logic                          busy_q,
  output logic                          soft_reset_q
);
  // ************************************************
  // Decode and phase sequencing
  // ************************************************
  crs_pkg::crs_op_t            op;
  logic                        shadow_sel;
  logic [10:0]                 offset;
  crs_pkg::crs_op_t            cur_q;
  logic                        cur_s_q;
  logic [crs_pkg::PC_W-1:0]    rel_q;
  logic [crs_pkg::PC_W-1:0]    stack_q [crs_pkg::DEPTH];
  logic                        ret_op;
  logic                        do_q4;
  logic                        sw_rst;

  crs_decode u_dec (
    .opcode     (opcode),
    .op         (op),
    .shadow_sel (shadow_sel),
    .offset     (offset)
  );

  assign ret_op = (cur_q == crs_pkg::CRS_RETI) || (cur_q == crs_pkg::CRS_RETL)
                || (cur_q == crs_pkg::CRS_RETS);
  assign do_q4  = (phase_q == crs_pkg::PH_Q4) && !busy_q;
  // Soft reset acts one edge after phase two starts
  assign sw_rst = soft_reset_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= crs_pkg::PH_Q1;
    end else if (sw_rst) begin
      phase_q <= crs_pkg::PH_Q1; // see [RULE6]
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur_q   <= crs_pkg::CRS_NONE;
      cur_s_q <= 1'b0;
      rel_q   <= crs_pkg::PC_RST;
    end else if (sw_rst) begin
      cur_q   <= crs_pkg::CRS_NONE;
      cur_s_q <= 1'b0;
      rel_q   <= crs_pkg::PC_RST;
    end else if (phase_q == crs_pkg::PH_Q1) begin
      cur_q   <= (op_valid && !busy_q) ? op : crs_pkg::CRS_NONE;
      cur_s_q <= shadow_sel;
      // Sign-extended offset doubled for byte addressing
      rel_q   <= {{(crs_pkg::PC_W-12){offset[10]}}, offset, 1'b0}; // see [RULE4]
    end
  end

  // Second cycle of two-cycle ops is a no-op
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else if (sw_rst) begin
      busy_q <= 1'b0;
    end else if (phase_q == crs_pkg::PH_Q4) begin
      busy_q <= !busy_q && (ret_op || cur_q == crs_pkg::CRS_RELATIVE_CALL_OP); // see [RULE5]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= !soft_reset_q && op_valid && !busy_q && op == crs_pkg::CRS_RESET
                      && phase_q == crs_pkg::PH_Q1; // see [RULE6]
    end
  end

  // ************************************************
  // Program counter and return stack
  // ************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= crs_pkg::PC_RST;
    end else if (sw_rst) begin
      pc_q <= crs_pkg::PC_RST;
    end else if (do_q4) begin
      if (cur_q == crs_pkg::CRS_RELATIVE_CALL_OP) begin
        pc_q <= pc_q + crs_pkg::PC_STEP + rel_q; // see [RULE4]
      end else if (ret_op) begin
        pc_q <= stack_top_value_q; // see [RULE8] [RULE13] [RULE15]
      end else begin
        pc_q <= pc_q + crs_pkg::PC_STEP;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sp_q <= '0;
    end else if (sw_rst) begin
      sp_q <= '0;
    end else if (do_q4 && (cur_q == crs_pkg::CRS_PUSH || cur_q == crs_pkg::CRS_RELATIVE_CALL_OP)) begin
      sp_q <= sp_q + 5'h01; // see [RULE17]
    end else if (do_q4 && ret_op) begin
      sp_q <= sp_q - 5'h01; // see [RULE17]
    end
  end

  // Stack top held separately; entries shift down on push, up on pop
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stack_top_value_q <= crs_pkg::PC_RST;
    end else if (sw_rst) begin
      stack_top_value_q <= crs_pkg::PC_RST;
    end else if (do_q4 && (cur_q == crs_pkg::CRS_PUSH || cur_q == crs_pkg::CRS_RELATIVE_CALL_OP)) begin
      stack_top_value_q <= pc_q + crs_pkg::PC_STEP; // see [RULE1] [RULE4]
    end else if (do_q4 && ret_op) begin
      stack_top_value_q <= stack_q[0];
    end
  end

  for (genvar i = 0; i < crs_pkg::DEPTH; i++) begin : g_stk
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        stack_q[i] <= crs_pkg::PC_RST;
      end else if (sw_rst) begin
        stack_q[i] <= crs_pkg::PC_RST;
      end else if (do_q4 && (cur_q == crs_pkg::CRS_PUSH || cur_q == crs_pkg::CRS_RELATIVE_CALL_OP)) begin
        stack_q[i] <= (i == 0) ? stack_top_value_q : stack_q[(i == 0) ? 0 : i-1]; // see [RULE1]
      end else if (do_q4 && ret_op) begin
        stack_q[i] <= (i == crs_pkg::DEPTH-1) ? crs_pkg::PC_RST
                    : stack_q[(i == crs_pkg::DEPTH-1) ? i : i+1];
      end
    end
  end

  // ************************************************
  // Working, flags, bank select and interrupt enables
  // ************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      working_q     <= crs_pkg::BYTE_RST;
      flags_q       <= crs_pkg::BYTE_RST;
      bank_select_q <= crs_pkg::BYTE_RST;
    end else if (sw_rst) begin
      working_q     <= crs_pkg::BYTE_RST;
      flags_q       <= crs_pkg::BYTE_RST;
      bank_select_q <= crs_pkg::BYTE_RST;
    end else if (do_q4 && cur_q == crs_pkg::CRS_RETL) begin
      working_q <= rel_q[8:1]; // see [RULE13]
    end else if (do_q4 && cur_s_q
                 && (cur_q == crs_pkg::CRS_RETI || cur_q == crs_pkg::CRS_RETS)) begin
      working_q     <= working_shadow; // see [RULE10] [RULE16]
      flags_q       <= flags_shadow;
      bank_select_q <= bank_select_shadow;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      global_irq_enable_high_q    <= 1'b0;
      peripheral_irq_enable_low_q <= 1'b0;
    end else if (sw_rst) begin
      global_irq_enable_high_q    <= 1'b0;
      peripheral_irq_enable_low_q <= 1'b0;
    end else if (do_q4 && cur_q == crs_pkg::CRS_RETI) begin
      if (irq_low_level) begin
        peripheral_irq_enable_low_q <= 1'b1; // see [RULE9]
      end else begin
        global_irq_enable_high_q <= 1'b1; // see [RULE9]
      end
    end
  end

  // Latches change only by direct write or reset, never by a return
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      upper_pc_latch_q <= 5'h00;
      high_pc_latch_q  <= crs_pkg::BYTE_RST;
    end else if (sw_rst) begin
      upper_pc_latch_q <= 5'h00;
      high_pc_latch_q  <= crs_pkg::BYTE_RST;
    end else if (latch_we) begin
      upper_pc_latch_q <= upper_pc_latch_in; // see [RULE11]
      high_pc_latch_q  <= high_pc_latch_in;
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  a_ret_pops_pc: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE8]
    do_q4 && ret_op && !sw_rst |=> pc_q == $past(stack_top_value_q))
    else $error("return did not load pc from stack top");
  a_call_target: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE4]
    do_q4 && cur_q == crs_pkg::CRS_RELATIVE_CALL_OP && !sw_rst
    |=> pc_q == $past(pc_q) + crs_pkg::PC_STEP + $past(rel_q)
        && stack_top_value_q == $past(pc_q) + crs_pkg::PC_STEP)
    else $error("relative call target wrong");
  a_push_shift: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE1]
    do_q4 && cur_q == crs_pkg::CRS_PUSH && !sw_rst
    |=> stack_q[0] == $past(stack_top_value_q))
    else $error("push did not move old top down");
  a_sp_step: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE17]
    do_q4 && ret_op && !sw_rst |=> sp_q == $past(sp_q) - 5'h01)
    else $error("pointer did not retreat on return");
  a_two_cycle: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE5]
    do_q4 && ret_op && !sw_rst |=> busy_q [*4])
    else $error("second cycle not a no-op");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE11]
    !latch_we && !sw_rst |=> $stable(high_pc_latch_q) && $stable(upper_pc_latch_q))
    else $error("pc latch changed without write");
  a_retl_w: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE13]
    do_q4 && cur_q == crs_pkg::CRS_RETL && !sw_rst
    |=> working_q == $past(rel_q[8:1]) && $stable(flags_q))
    else $error("literal return wrong");
  a_shadow_off: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE16]
    do_q4 && !cur_s_q && cur_q == crs_pkg::CRS_RETS && !sw_rst
    |=> $stable(working_q) && $stable(bank_select_q))
    else $error("restore without option bit");
  a_irq_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE9]
    do_q4 && cur_q == crs_pkg::CRS_RETI && !sw_rst
    |=> global_irq_enable_high_q || peripheral_irq_enable_low_q)
    else $error("interrupt enable not set");
  a_soft_rst: assert property (@(posedge clk_sys) disable iff (!reset_n) // see [RULE6]
    soft_reset_q |=> pc_q == crs_pkg::PC_RST && sp_q == '0 && !soft_reset_q)
    else $error("soft reset incomplete");

  c_relative_call_op: cover property (@(posedge clk_sys) do_q4 && cur_q == crs_pkg::CRS_RELATIVE_CALL_OP);
  c_reti_s: cover property (@(posedge clk_sys) do_q4 && cur_q == crs_pkg::CRS_RETI && cur_s_q);
  c_retl: cover property (@(posedge clk_sys) do_q4 && cur_q == crs_pkg::CRS_RETL);
  c_reset: cover property (@(posedge clk_sys) soft_reset_q);
endmodule

/* sim/call_return_stack_ops_bench.sv */
// Self-checking bench for the call and return execution block
`timescale 1ns/1ps
module call_return_stack_ops_bench;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic                        clk_sys;
  logic                        reset_n;
  logic [15:0]                 opcode;
  logic                        op_valid;
  logic                        irq_low_level;
  logic [7:0]                  working_shadow;
  logic [7:0]                  flags_shadow;
  logic [7:0]                  bank_select_shadow;
  logic [4:0]                  upper_pc_latch_in;
  logic [7:0]                  high_pc_latch_in;
  logic                        latch_we;
  logic [crs_pkg::PC_W-1:0]    pc_q;
  logic [crs_pkg::PC_W-1:0]    stack_top_value_q;
  logic [crs_pkg::SP_W-1:0]    sp_q;
  logic [7:0]                  working_q;
  logic [7:0]                  flags_q;
  logic [7:0]                  bank_select_q;
  logic                        global_irq_enable_high_q;
  logic                        peripheral_irq_enable_low_q;
  logic [4:0]                  upper_pc_latch_q;
  logic [7:0]                  high_pc_latch_q;
  logic [1:0]                  phase_q;
  logic                        busy_q;
  logic                        soft_reset_q;
  int                          n_fail;
  int                          tests_run;

  crs_core dut_u (
    .clk_sys                     (clk_sys),
    .reset_n                     (reset_n),
    .opcode                      (opcode),
    .op_valid                    (op_valid),
    .irq_low_level               (irq_low_level),
    .working_shadow              (working_shadow),
    .flags_shadow                (flags_shadow),
    .bank_select_shadow          (bank_select_shadow),
    .upper_pc_latch_in           (upper_pc_latch_in),
    .high_pc_latch_in            (high_pc_latch_in),
    .latch_we                    (latch_we),
    .pc_q                        (pc_q),
    .stack_top_value_q           (stack_top_value_q),
    .sp_q                        (sp_q),
    .working_q                   (working_q),
    .flags_q                     (flags_q),
    .bank_select_q               (bank_select_q),
    .global_irq_enable_high_q    (global_irq_enable_high_q),
    .peripheral_irq_enable_low_q (peripheral_irq_enable_low_q),
    .upper_pc_latch_q            (upper_pc_latch_q),
    .high_pc_latch_q             (high_pc_latch_q),
    .phase_q                     (phase_q),
    .busy_q                      (busy_q),
    .soft_reset_q                (soft_reset_q)
  );

  // ****************************************
  // Clock and helper tasks
  // ****************************************
  always #20 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Presents one opcode at a free Q1 and waits the given edges after the take
  task automatic issue(input logic [15:0] op, input int waits);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (!(phase_q === 2'h0 && busy_q === 1'b0) && n < 32) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 32) n_fail++;
    opcode = op;
    op_valid = 1'b1;
    @(negedge clk_sys);
    op_valid = 1'b0;
    repeat (waits) @(negedge clk_sys);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (1000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    opcode = 16'h0000;
    op_valid = 1'b0;
    irq_low_level = 1'b0;
    working_shadow = 8'hA5;
    flags_shadow = 8'h5A;
    bank_select_shadow = 8'h3C;
    upper_pc_latch_in = 5'h15;
    high_pc_latch_in = 8'hC3;
    latch_we = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    latch_we = 1'b1;
    @(negedge clk_sys);
    latch_we = 1'b0;
    chk(32'(pc_q), 32'h0);
    chk(32'(high_pc_latch_q), 32'hC3);
    $display("Test reset and latches done");
    // Idle cycles advance pc by 2, one precedes each op after a one-cycle op
    issue(crs_pkg::OP_PUSH, 3);
    chk(32'(pc_q), 32'h4);
    chk(32'(stack_top_value_q), 32'h4);
    chk(32'(sp_q), 32'h1);
    issue(16'hDBFF, 3);
    chk(32'(stack_top_value_q), 32'h8);
    chk(32'(pc_q), 32'h806);
    chk(32'(sp_q), 32'h2);
    chk(32'(busy_q), 32'h1);
    issue(16'hDC00, 3);
    chk(32'(stack_top_value_q), 32'h808);
    chk(32'(pc_q), 32'h8);
    chk(32'(sp_q), 32'h3);
    $display("Test push and relative call done");
    issue(16'h0CFF, 3);
    chk(32'(pc_q), 32'h808);
    chk(32'(working_q), 32'hFF);
    chk(32'(stack_top_value_q), 32'h8);
    chk(32'(flags_q), 32'h0);
    chk(32'(sp_q), 32'h2);
    issue(16'h0013, 3);
    chk(32'(pc_q), 32'h8);
    chk(32'(working_q), 32'hA5);
    chk(32'(flags_q), 32'h5A);
    chk(32'(bank_select_q), 32'h3C);
    chk(32'(global_irq_enable_high_q), 32'h0);
    chk(32'(stack_top_value_q), 32'h4);
    chk(32'(upper_pc_latch_q), 32'h15);
    $display("Test literal and subroutine return done");
    irq_low_level = 1'b1;
    working_shadow = 8'h11;
    flags_shadow = 8'h22;
    bank_select_shadow = 8'h33;
    issue(16'h0010, 3);
    chk(32'(pc_q), 32'h4);
    chk(32'(peripheral_irq_enable_low_q), 32'h1);
    chk(32'(global_irq_enable_high_q), 32'h0);
    chk(32'(working_q), 32'hA5);
    chk(32'(flags_q), 32'h5A);
    chk(32'(sp_q), 32'h0);
    chk(32'(high_pc_latch_q), 32'hC3);
    issue(crs_pkg::OP_PUSH, 3);
    chk(32'(stack_top_value_q), 32'h6);
    irq_low_level = 1'b0;
    issue(16'h0011, 3);
    chk(32'(pc_q), 32'h6);
    chk(32'(stack_top_value_q), 32'h0);
    chk(32'(global_irq_enable_high_q), 32'h1);
    chk(32'(working_q), 32'h11);
    chk(32'(flags_q), 32'h22);
    chk(32'(bank_select_q), 32'h33);
    $display("Test interrupt return done");
    working_shadow = 8'h44;
    bank_select_shadow = 8'h55;
    issue(crs_pkg::OP_PUSH, 3);
    chk(32'(pc_q), 32'h8);
    issue(16'h0012, 3);
    chk(32'(pc_q), 32'h8);
    chk(32'(working_q), 32'h11);
    chk(32'(bank_select_q), 32'h33);
    chk(32'(sp_q), 32'h0);
    $display("Test return without restore done");
    issue(crs_pkg::OP_RESET, 0);
    chk(32'(soft_reset_q), 32'h1);
    @(negedge clk_sys);
    chk(32'(pc_q), 32'h0);
    chk(32'(sp_q), 32'h0);
    chk(32'(working_q), 32'h0);
    chk(32'(global_irq_enable_high_q), 32'h0);
    chk(32'(phase_q), 32'h0);
    $display("Test software reset done");
    print_verdict();
  end
endmodule
